/* rtl/glpm_cfg.svh */
// Constants for the lamp and general-purpose pin multiplexer
`ifndef GLPM_CFG_SVH
`define GLPM_CFG_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define GLPM_CLK_HZ 20000000
`define GLPM_MS_PER_S 1000
`define GLPM_BLINK_MS 80
`define GLPM_BLINK_CYCLES (`GLPM_CLK_HZ / `GLPM_MS_PER_S * `GLPM_BLINK_MS)
// ------------------------------------------------------------
// Pin and synchroniser bit positions
// ------------------------------------------------------------
`define GLPM_PIN_SPEED 0
`define GLPM_PIN_LINK 1
`define GLPM_PIN_DUPLEX 2
`define GLPM_SYNC_W 8
`define GLPM_SY_RX_DV 0
`define GLPM_SY_RX_CLK 1
`define GLPM_SY_TX_EN 2
`define GLPM_SY_TX_CLK 3
`define GLPM_SY_GPIO_LO 4
`define GLPM_SY_GPIO_HI 6
`define GLPM_SY_MEM_DATA 7
// ------------------------------------------------------------
// Levels and reset values
// ------------------------------------------------------------
`define GLPM_SEL_IDLE 1'b0
`define GLPM_RST_BIT 1'b0
`define GLPM_RST_VEC3 3'h0
`define GLPM_RST_SYNC 8'h00
`define GLPM_LAMP_OFF 3'h7
`endif

/* rtl/glpm_pkg.sv */
// Types for the lamp and general-purpose pin multiplexer
package glpm_pkg;
	// Drive style of a general-purpose pin
	typedef enum logic [1:0] {
		GLPM_DRV_IN = 2'h0,
		GLPM_DRV_PP = 2'h1,
		GLPM_DRV_OD = 2'h2,
		GLPM_DRV_RSV = 2'h3
	} glpm_drive_type;
	// Role of a configuration-memory pin
	typedef enum logic [1:0] {
		GLPM_FN_MEM = 2'h0,
		GLPM_FN_GPO = 2'h1,
		GLPM_FN_MON_SIG = 2'h2,
		GLPM_FN_MON_CLK = 2'h3
	} glpm_fn_type;
	// Activity blink sequencer, one-hot
	typedef enum logic [2:0] {
		GLPM_BL_SOLID = 3'h1,
		GLPM_BL_DARK = 3'h2,
		GLPM_BL_HOLD = 3'h4
	} glpm_blink_type;
	// Per-pin configuration
	typedef struct packed {
		logic lamp_en;
		glpm_drive_type drive;
		logic out_val;
	} glpm_pin_cfg_type;
	// Configuration-memory pin roles
	typedef struct packed {
		glpm_fn_type clk_fn;
		logic gp_output_b;
		glpm_fn_type data_fn;
		logic gp_output_a;
	} glpm_alt_cfg_type;
	// Link status from the internal transceiver
	typedef struct packed {
		logic link_up;
		logic speed_10;
		logic autoneg_busy;
		logic full_duplex;
		logic activity;
	} glpm_phy_stat_type;
	// Drive from the configuration-memory controller
	typedef struct packed {
		logic clk;
		logic sel;
		logic data_o;
		logic data_oe;
	} glpm_mem_drv_type;
endpackage

/* rtl/glpm_top.sv */
// Lamp, general-purpose pin and configuration-memory pin multiplexer
`timescale 1ns/1ps
`include "glpm_cfg.svh"

// Summary of operation
// - Memory clock pin: output or receive monitor
// - Memory select idle while pins repurposed
// - Memory clock pin has no input role
// - Each GPIO is push-pull, open-drain or input
// - Lamp role drives open-drain, low means on
// - Speed lamp released only at 10 Mb/s
// - Link lamp low while link valid, except in the dark blink phase
// - Activity: 80 ms dark, 80 ms lit, repeat
// - Duplex lamp low in full duplex
// - Memory data pin: output or transmit monitor
module glpm_top #(
	parameter int BLINK_CYCLES = `GLPM_BLINK_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic CFG_LOAD,
	input wire glpm_pkg::glpm_pin_cfg_type [2:0] GPIO_CFG,
	input wire glpm_pkg::glpm_alt_cfg_type ALT_CFG,
	input wire glpm_pkg::glpm_phy_stat_type PHY_STAT,
	input wire glpm_pkg::glpm_mem_drv_type MEM_DRV,
	input wire logic MII_RX_DV,
	input wire logic MII_RX_CLK,
	input wire logic MII_TX_EN,
	input wire logic MII_TX_CLK,
	input wire logic [2:0] GPIO_I,
	output logic [2:0] GPIO_O,
	output logic [2:0] GPIO_OE,
	output logic [2:0] GPIO_IN_VAL,
	output logic CFG_MEM_CLOCK_PIN,
	output logic CFG_MEM_SELECT,
	input wire logic CFG_MEM_DATA_PIN_I,
	output logic CFG_MEM_DATA_PIN_O,
	output logic CFG_MEM_DATA_PIN_OE,
	output logic CFG_MEM_DATA_IN
);
	import glpm_pkg::*;

	localparam int CW = $clog2(BLINK_CYCLES + 1);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	generate
		if (BLINK_CYCLES < 1) begin : g_bad_blink
			$error("BLINK_CYCLES must be at least one");
		end
	endgenerate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	glpm_pin_cfg_type [2:0] pin_cfg_reg, pin_cfg_next; // Loaded config
	glpm_alt_cfg_type alt_cfg_reg, alt_cfg_next; // Memory pin roles
	logic [`GLPM_SYNC_W-1:0] sync1_reg, sync1_next; // First stage only
	logic [`GLPM_SYNC_W-1:0] sync2_reg, sync2_next; // Safe to read
	glpm_blink_type blink_reg, blink_next; // Activity sequencer
	logic [CW-1:0] cnt_reg, cnt_next; // Phase timer
	logic pend_reg, pend_next; // Activity seen while lit
	logic [2:0] gpio_o_next, gpio_oe_next, gpio_in_next;
	logic mclk_next, msel_next, mdo_next, mdoe_next, mdin_next;
	logic [2:0] lamp_n; // Lamp level, high means released
	logic [CW-1:0] cnt_load; // Reload value, one less than the phase length

	assign cnt_load = CW'(BLINK_CYCLES - 1);

	// ------------------------------------------------------------
	// Configuration capture
	// ------------------------------------------------------------
	// Held until software loads new values, so reset defaults stick
	always_comb begin
		pin_cfg_next = pin_cfg_reg;
		alt_cfg_next = alt_cfg_reg;
		if (CFG_LOAD) begin
			pin_cfg_next = GPIO_CFG;
			alt_cfg_next = ALT_CFG;
		end
		// Pins crossing from outside go through two flops
		sync1_next = {CFG_MEM_DATA_PIN_I, GPIO_I, MII_TX_CLK, MII_TX_EN,
			MII_RX_CLK, MII_RX_DV};
		sync2_next = sync1_reg;
	end

	// ------------------------------------------------------------
	// Activity blink sequencer
	// ------------------------------------------------------------
	// Activity during the dark phase is absorbed; activity during the
	// lit phase is remembered so the next blink follows at once.
	always_comb begin
		blink_next = blink_reg;
		cnt_next = cnt_reg;
		pend_next = pend_reg;
		if (!PHY_STAT.link_up) begin
			// No link: back to rest, nothing pending
			blink_next = GLPM_BL_SOLID;
			cnt_next = '0;
			pend_next = 1'b0;
		end else begin
			case (blink_reg)
				GLPM_BL_SOLID: begin
					if (PHY_STAT.activity) begin
						blink_next = GLPM_BL_DARK;
						cnt_next = cnt_load;
					end
				end
				GLPM_BL_DARK: begin
					if (cnt_reg == '0) begin
						blink_next = GLPM_BL_HOLD;
						cnt_next = cnt_load;
						pend_next = 1'b0;
					end else begin
						cnt_next = cnt_reg - 1'b1;
					end
				end
				GLPM_BL_HOLD: begin
					// Activity on the final lit cycle still starts the next dark phase
					pend_next = pend_reg | PHY_STAT.activity;
					if (cnt_reg == '0) begin
						if (pend_reg || PHY_STAT.activity) begin
							blink_next = GLPM_BL_DARK;
							cnt_next = cnt_load;
						end else begin
							blink_next = GLPM_BL_SOLID;
						end
						pend_next = 1'b0;
					end else begin
						cnt_next = cnt_reg - 1'b1;
					end
				end
				default: begin
					blink_next = GLPM_BL_SOLID;
					cnt_next = '0;
					pend_next = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Lamp levels
	// ------------------------------------------------------------
	always_comb begin
		// Released only when linked at 10 Mb/s with negotiation done
		lamp_n[`GLPM_PIN_SPEED] = PHY_STAT.link_up & PHY_STAT.speed_10 &
			~PHY_STAT.autoneg_busy;
		// Lit on link, released during the dark blink phase
		lamp_n[`GLPM_PIN_LINK] = ~(PHY_STAT.link_up &
			(blink_reg != GLPM_BL_DARK));
		lamp_n[`GLPM_PIN_DUPLEX] = ~(PHY_STAT.link_up &
			PHY_STAT.full_duplex);
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// All pins see registered drive, so pin edges never glitch
	always_comb begin
		gpio_o_next = `GLPM_RST_VEC3;
		gpio_oe_next = `GLPM_RST_VEC3;
		for (int i = 0; i < 3; i++) begin
			if (pin_cfg_reg[i].lamp_en) begin
				gpio_oe_next[i] = ~lamp_n[i];
			end else begin
				case (pin_cfg_reg[i].drive)
					GLPM_DRV_PP: begin
						gpio_o_next[i] = pin_cfg_reg[i].out_val;
						gpio_oe_next[i] = 1'b1;
					end
					GLPM_DRV_OD: begin
						gpio_oe_next[i] = ~pin_cfg_reg[i].out_val;
					end
					default: begin
						// Input or unused code: pin left floating
						gpio_oe_next[i] = 1'b0;
					end
				endcase
			end
		end
		gpio_in_next = sync2_reg[`GLPM_SY_GPIO_HI:`GLPM_SY_GPIO_LO];
		// Clock pin is output only; its sampled level is never used
		case (alt_cfg_reg.clk_fn)
			GLPM_FN_GPO: mclk_next = alt_cfg_reg.gp_output_b;
			GLPM_FN_MON_SIG: mclk_next = sync2_reg[`GLPM_SY_RX_DV];
			GLPM_FN_MON_CLK: mclk_next = sync2_reg[`GLPM_SY_RX_CLK];
			default: mclk_next = MEM_DRV.clk;
		endcase
		case (alt_cfg_reg.data_fn)
			GLPM_FN_GPO: mdo_next = alt_cfg_reg.gp_output_a;
			GLPM_FN_MON_SIG: mdo_next = sync2_reg[`GLPM_SY_TX_EN];
			GLPM_FN_MON_CLK: mdo_next = sync2_reg[`GLPM_SY_TX_CLK];
			default: mdo_next = MEM_DRV.data_o;
		endcase
		// Repurposed data pin is always driven
		mdoe_next = (alt_cfg_reg.data_fn == GLPM_FN_MEM) ?
			MEM_DRV.data_oe : 1'b1;
		// Either pin repurposed: memory must never see a select
		msel_next = (alt_cfg_reg.clk_fn == GLPM_FN_MEM &&
			alt_cfg_reg.data_fn == GLPM_FN_MEM) ?
			MEM_DRV.sel : `GLPM_SEL_IDLE;
		mdin_next = sync2_reg[`GLPM_SY_MEM_DATA];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			// Default roles: inputs, no lamps, memory owns its pins
			for (int i = 0; i < 3; i++) begin
				pin_cfg_reg[i] <= '{lamp_en: `GLPM_RST_BIT,
					drive: GLPM_DRV_IN, out_val: `GLPM_RST_BIT};
			end
			alt_cfg_reg <= '{clk_fn: GLPM_FN_MEM, gp_output_b: `GLPM_RST_BIT,
				data_fn: GLPM_FN_MEM, gp_output_a: `GLPM_RST_BIT};
			sync1_reg <= `GLPM_RST_SYNC;
			sync2_reg <= `GLPM_RST_SYNC;
			blink_reg <= GLPM_BL_SOLID;
			cnt_reg <= '0;
			pend_reg <= `GLPM_RST_BIT;
			GPIO_O <= `GLPM_RST_VEC3;
			GPIO_OE <= `GLPM_RST_VEC3;
			GPIO_IN_VAL <= `GLPM_RST_VEC3;
			CFG_MEM_CLOCK_PIN <= `GLPM_RST_BIT;
			CFG_MEM_SELECT <= `GLPM_SEL_IDLE;
			CFG_MEM_DATA_PIN_O <= `GLPM_RST_BIT;
			CFG_MEM_DATA_PIN_OE <= `GLPM_RST_BIT;
			CFG_MEM_DATA_IN <= `GLPM_RST_BIT;
		end else begin
			pin_cfg_reg <= pin_cfg_next;
			alt_cfg_reg <= alt_cfg_next;
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			blink_reg <= blink_next;
			cnt_reg <= cnt_next;
			pend_reg <= pend_next;
			GPIO_O <= gpio_o_next;
			GPIO_OE <= gpio_oe_next;
			GPIO_IN_VAL <= gpio_in_next;
			CFG_MEM_CLOCK_PIN <= mclk_next;
			CFG_MEM_SELECT <= msel_next;
			CFG_MEM_DATA_PIN_O <= mdo_next;
			CFG_MEM_DATA_PIN_OE <= mdoe_next;
			CFG_MEM_DATA_IN <= mdin_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Blink start and freshly loaded dark phase, as named steps
	sequence s_blink_start;
		blink_reg == GLPM_BL_SOLID && PHY_STAT.link_up && PHY_STAT.activity;
	endsequence
	sequence s_dark_loaded;
		blink_reg == GLPM_BL_DARK && cnt_reg == cnt_load;
	endsequence

	property p_sel_idle;
		@(posedge CLK_SYS) disable iff (SRST)
		(alt_cfg_reg.clk_fn != GLPM_FN_MEM) |=> !CFG_MEM_SELECT;
	endproperty
	a_sel_idle: assert property (p_sel_idle)
		else $error("memory select active while clock pin repurposed");

	property p_clk_mon;
		@(posedge CLK_SYS) disable iff (SRST)
		(alt_cfg_reg.clk_fn == GLPM_FN_MON_SIG) |=>
			CFG_MEM_CLOCK_PIN == $past(sync2_reg[`GLPM_SY_RX_DV]);
	endproperty
	a_clk_mon: assert property (p_clk_mon)
		else $error("clock pin does not follow receive valid");

	property p_data_drive;
		@(posedge CLK_SYS) disable iff (SRST)
		(alt_cfg_reg.data_fn == GLPM_FN_GPO) |=>
			CFG_MEM_DATA_PIN_OE && !CFG_MEM_SELECT &&
			CFG_MEM_DATA_PIN_O == $past(alt_cfg_reg.gp_output_a);
	endproperty
	a_data_drive: assert property (p_data_drive)
		else $error("data pin output role wrong");

	property p_gpio_pp;
		@(posedge CLK_SYS) disable iff (SRST)
		(!pin_cfg_reg[0].lamp_en && pin_cfg_reg[0].drive == GLPM_DRV_PP)
			|=> GPIO_OE[0] && GPIO_O[0] == $past(pin_cfg_reg[0].out_val);
	endproperty
	a_gpio_pp: assert property (p_gpio_pp)
		else $error("push-pull pin not driving its bit");

	property p_speed_lamp;
		@(posedge CLK_SYS) disable iff (SRST)
		(pin_cfg_reg[0].lamp_en && PHY_STAT.link_up && !PHY_STAT.speed_10)
			|=> GPIO_OE[0] && !GPIO_O[0];
	endproperty
	a_speed_lamp: assert property (p_speed_lamp)
		else $error("speed lamp not pulled low at 100 Mb/s");

	property p_blink_start;
		@(posedge CLK_SYS) disable iff (SRST)
		s_blink_start |=> s_dark_loaded ##1
			(!pin_cfg_reg[1].lamp_en || !GPIO_OE[1]);
	endproperty
	a_blink_start: assert property (p_blink_start)
		else $error("activity did not start a full dark phase");

	property p_dark_end;
		@(posedge CLK_SYS) disable iff (SRST)
		(blink_reg == GLPM_BL_DARK && cnt_reg == '0 && PHY_STAT.link_up)
			|=> blink_reg == GLPM_BL_HOLD && cnt_reg == cnt_load;
	endproperty
	a_dark_end: assert property (p_dark_end)
		else $error("dark phase not followed by full lit phase");

	property p_link_lamp;
		@(posedge CLK_SYS) disable iff (SRST)
		(pin_cfg_reg[1].lamp_en && PHY_STAT.link_up &&
			blink_reg != GLPM_BL_DARK) |=> GPIO_OE[1] && !GPIO_O[1];
	endproperty
	a_link_lamp: assert property (p_link_lamp)
		else $error("link lamp not lit on valid link");

	property p_reset_roles;
		@(posedge CLK_SYS)
		SRST |=> GPIO_OE == `GLPM_RST_VEC3 && !CFG_MEM_SELECT &&
			alt_cfg_reg.clk_fn == GLPM_FN_MEM && !pin_cfg_reg[2].lamp_en;
	endproperty
	a_reset_roles: assert property (p_reset_roles)
		else $error("reset did not restore default pin roles");

endmodule

/* test/glpm_board.sv */
// Board model: lamp pull-ups, external pin drivers and memory data line
`timescale 1ns/1ps
module glpm_board (
	input wire logic [2:0] gpio_o,
	input wire logic [2:0] gpio_oe,
	input wire logic [2:0] ext_en,
	input wire logic [2:0] ext_val,
	input wire logic data_o,
	input wire logic data_oe,
	input wire logic mem_en,
	input wire logic mem_dout,
	output logic [2:0] gpio_pin,
	output logic data_pin
);
	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	// Lamp lines carry pull-ups, so a released line reads high
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			gpio_pin[i] = gpio_oe[i] ? gpio_o[i] :
				(ext_en[i] ? ext_val[i] : 1'h1);
		end
		// Memory drives only while the controller lets go of the line
		data_pin = data_oe ? data_o : (mem_en ? mem_dout : 1'h1);
	end
endmodule

/* test/gpio_led_gpo_pin_mux_tb.sv */
// Self-checking bench for the lamp and pin multiplexer
`timescale 1ns/1ps
module gpio_led_gpo_pin_mux_tb;
	import glpm_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	localparam int N = 8; // Short blink period keeps the run brief
	logic clk_sys = 1'h0;
	logic srst = 1'h1;
	logic cfg_load = 1'h0;
	glpm_pin_cfg_type [2:0] gpio_cfg = '0;
	glpm_alt_cfg_type alt_cfg = '0;
	glpm_phy_stat_type phy = '0;
	glpm_mem_drv_type mem = 4'h4; // Select requested from time zero
	logic rx_dv = 1'h0, rx_clk = 1'h0, tx_en = 1'h0, tx_clk = 1'h0;
	logic [2:0] ext_en = 3'h0, ext_val = 3'h0;
	logic mem_en = 1'h0, mem_dout = 1'h0;
	logic [2:0] g_o, g_oe, g_in, pin;
	logic clk_pin, sel, d_o, d_oe, d_in, d_pin;
	int errors = 0, n_tests = 0;

	always #25 clk_sys = ~clk_sys;

	glpm_top #(.BLINK_CYCLES(N)) dut (.CLK_SYS(clk_sys), .SRST(srst),
		.CFG_LOAD(cfg_load), .GPIO_CFG(gpio_cfg), .ALT_CFG(alt_cfg),
		.PHY_STAT(phy), .MEM_DRV(mem), .MII_RX_DV(rx_dv),
		.MII_RX_CLK(rx_clk), .MII_TX_EN(tx_en), .MII_TX_CLK(tx_clk),
		.GPIO_I(pin), .GPIO_O(g_o), .GPIO_OE(g_oe), .GPIO_IN_VAL(g_in),
		.CFG_MEM_CLOCK_PIN(clk_pin), .CFG_MEM_SELECT(sel),
		.CFG_MEM_DATA_PIN_I(d_pin), .CFG_MEM_DATA_PIN_O(d_o),
		.CFG_MEM_DATA_PIN_OE(d_oe), .CFG_MEM_DATA_IN(d_in));

	glpm_board board (.gpio_o(g_o), .gpio_oe(g_oe), .ext_en(ext_en),
		.ext_val(ext_val), .data_o(d_o), .data_oe(d_oe), .mem_en(mem_en),
		.mem_dout(mem_dout), .gpio_pin(pin), .data_pin(d_pin));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Inputs always move 5 ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask

	task automatic check(input logic seen, input logic exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask

	// Outputs follow the loaded settings two edges after the strobe
	task automatic load();
		cfg_load = 1'h1;
		tick(1);
		cfg_load = 1'h0;
		tick(2);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset with pins repurposed must fall back to memory roles
	task automatic t_reset(input int n);
		srst = 1'h1;
		mem = 4'hC;
		tick(n);
		check(sel, 1'h0);
		check(|g_oe, 1'h0);
		srst = 1'h0;
		tick(2);
		check(sel, 1'h1);
		check(clk_pin, 1'h1);
		check(d_oe, 1'h0);
		check(|g_oe, 1'h0);
		$display("t_reset done");
	endtask

	// Every drive code, both output values, pin level fed back
	task automatic t_gpio();
		logic oe, o;
		ext_en = 3'h7;
		for (int d = 0; d < 4; d++) begin
			for (int v = 0; v < 2; v++) begin
				for (int i = 0; i < 3; i++) gpio_cfg[i] = {1'h0, 2'(d), 1'(v)};
				ext_val = {3{~1'(v)}};
				load();
				tick(3);
				oe = (d == 1) || (d == 2 && v == 0);
				o = (d == 1) ? 1'(v) : 1'h0;
				for (int i = 0; i < 3; i++) begin
					check(g_oe[i], oe);
					if (oe) check(g_o[i], o);
					check(pin[i], oe ? o : ~1'(v));
					check(g_in[i], oe ? o : ~1'(v));
				end
			end
		end
		ext_en = 3'h0;
		$display("t_gpio done");
	endtask

	// All link states with the three lamps enabled
	task automatic t_lamps();
		for (int i = 0; i < 3; i++) gpio_cfg[i] = 4'h8;
		load();
		for (int s = 0; s < 16; s++) begin
			phy = {4'(s), 1'h0};
			tick(1);
			check(g_oe[0], !(s[3] && s[2] && !s[1]));
			check(pin[0], s[3] && s[2] && !s[1]);
			check(g_oe[1], s[3]);
			check(g_oe[2], s[3] && s[0]);
			check(|g_o, 1'h0);
		end
		$display("t_lamps done");
	endtask

	// Round 0: activity while dark is ignored; round 1: while lit repeats
	task automatic t_blink();
		for (int r = 0; r < 2; r++) begin
			phy = 5'h10;
			tick(1);
			phy = 5'h11;
			tick(1);
			phy = 5'h10;
			tick(1);
			// Lamp goes dark two edges after the activity edge
			check(g_oe[1], 1'h0);
			// Dark for the first N-1 loop edges, then lit for N edges
			for (int j = 0; j < 2 * N - 1; j++) begin
				phy = (j == 2 + r * N) ? 5'h11 : 5'h10;
				tick(1);
				check(g_oe[1], j >= N - 1);
			end
			phy = 5'h10;
			tick(1);
			check(g_oe[1], r == 0);
			phy = 5'h00;
			tick(2);
		end
		phy = 5'h10;
		$display("t_blink done");
	endtask

	// Every role of both memory pins with distinct source patterns
	task automatic t_mem();
		logic e_clk, e_dat, e_oe;
		int fc, fd;
		mem_en = 1'h1;
		for (int k = 0; k < 8; k++) begin
			for (int v = 0; v < 4; v++) begin
				fc = (k < 4) ? k : 0;
				fd = (k < 4) ? 0 : k - 4;
				alt_cfg = {2'(fc), v[1], 2'(fd), v[0]};
				mem = {v[0], 1'h1, v[1], v[0]};
				rx_dv = v[0] ^ v[1];
				rx_clk = ~v[0];
				tx_en = v[0] ^ v[1];
				tx_clk = ~v[1];
				mem_dout = ~v[1];
				load();
				tick(3);
				e_clk = fc == 0 ? v[0] : fc == 1 ? v[1] : fc == 2 ? rx_dv : rx_clk;
				e_dat = fd == 0 ? v[1] : fd == 1 ? v[0] : fd == 2 ? tx_en : tx_clk;
				e_oe = fd != 0 || v[0];
				check(clk_pin, e_clk);
				check(sel, fc == 0 && fd == 0);
				check(d_oe, e_oe);
				if (e_oe) check(d_o, e_dat);
				else check(d_in, mem_dout);
			end
		end
		$display("t_mem done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		t_reset(16);
		t_gpio();
		t_lamps();
		t_blink();
		t_mem();
		t_reset(2);
		end_of_test();
	end
endmodule
